// *** logic/timer_core.v ***
// Purpose: Timer core with counter, compare A/P, capture, output pins.
// Assumes: high_clock and sub_clock enters as synchronous levels.
// Notes:   AHB-Lite slave, zero wait states, always OKAY.
//
// How it works
// - Up counter compared with each comparator; a match raises its event.
// - A match may clear the counter and change the output pin.
// - Three-bit field picks system, divided system, divided high, sub or pin clock.
// - External clock counts on rising or falling edge as selected.
// - Single pulse mode is triggered by the external clock pin.
// - Capture pin edge rising, falling or both from the pin field.
// - Separate event outputs for compare A and compare P matches.
// - Inverted output pin is always the inverse of the main pin.
// - Compare mode drives pins high, low or toggles on match.
// - PWM leaves on the same two output pins.
// - Edge-aligned PWM with duty or period set by comparators.
// - Counter and compare A split into bytes; low via one buffer.
// - Writing a low byte only loads the shared buffer.
// - Writing the compare A high byte also copies the buffer into its low byte.
// - Reading a high byte also copies its low byte into the buffer.
// - Reading a low byte returns the shared buffer.
// - Comparator P is 8 bits against counter bits 15:8.
// - Codes 110 and 111 select external rising and falling edge.
`timescale 1ns/100ps
`include "timer_core_map.vh"

module timer_core (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Clock sources and pins
  input  wire        high_clock,
  input  wire        sub_clock,
  input  wire        ext_clock_pin,
  input  wire        capture_input_pin,
  output reg         timer_output_pin,
  output reg         timer_output_inverted_pin,
  // Events
  output reg         match_a_evt,
  output reg         match_p_evt,
  output reg         capture_evt
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [7:0]  ctrl0_r;
  reg  [7:0]  ctrl1_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cmpa_r;
  reg  [7:0]  per_r;
  reg  [7:0]  buf_r;
  reg  [7:0]  stat_r;
  reg         out_r;
  reg         on_d_r;
  reg         pulse_r;
  reg  [1:0]  div4_r;
  reg  [3:0]  div16_r;
  reg  [5:0]  div64_r;
  reg         h_d_r;
  reg         s_d_r;
  reg  [2:0]  eck_r;
  reg  [2:0]  cap_r;
  reg         ph_wr_r;
  reg         ph_rd_r;
  reg  [7:0]  ph_addr_r;

  wire [2:0] cks  = ctrl0_r[`C0_CKS_HI:`C0_CKS_LO];
  wire [1:0] mode = ctrl1_r[`C1_MODE_HI:`C1_MODE_LO];
  wire [1:0] io   = ctrl1_r[`C1_IO_HI:`C1_IO_LO];
  wire       on   = ctrl0_r[`C0_ON];
  wire       oc   = ctrl1_r[`C1_OC];

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  // Edges taken between stages 1 and 2; stage 0 only feeds stage 1
  wire eck_rise = eck_r[1] & ~eck_r[2];
  wire eck_fall = ~eck_r[1] & eck_r[2];
  wire cap_rise = cap_r[1] & ~cap_r[2];
  wire cap_fall = ~cap_r[1] & cap_r[2];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eck_r <= 3'h0;
      cap_r <= 3'h0;
      h_d_r <= 1'b0;
      s_d_r <= 1'b0;
    end else begin
      eck_r <= {eck_r[1:0], ext_clock_pin};
      cap_r <= {cap_r[1:0], capture_input_pin};
      h_d_r <= high_clock;
      s_d_r <= sub_clock;
    end
  end

  // ----------------------------------------
  // Clock source selection
  // ----------------------------------------
  // Slow clocks arrive as levels; count their rising edges
  wire h_rise = high_clock & ~h_d_r;
  wire s_rise = sub_clock & ~s_d_r;
  reg  tick;

  always @* begin
    case (cks)
      `CKS_SYS4:     tick = (div4_r == `DIV_SYS4);
      `CKS_SYS1:     tick = 1'b1;
      `CKS_H16:      tick = h_rise & (div16_r == `DIV_H16);
      `CKS_H64:      tick = h_rise & (div64_r == `DIV_H64);
      `CKS_EXT_RISE: tick = eck_rise;
      `CKS_EXT_FALL: tick = eck_fall;
      default:       tick = s_rise;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div4_r  <= 2'h0;
      div16_r <= 4'h0;
      div64_r <= 6'h0;
    end else begin
      div4_r <= div4_r + 2'h1;
      if (h_rise) begin
        div16_r <= div16_r + 4'h1;
        div64_r <= div64_r + 6'h1;
      end
    end
  end

  // ----------------------------------------
  // Data-phase write strobes
  // ----------------------------------------
  // Status clear feeds the flag logic below
  wire wr_stat  = ph_wr_r & (ph_addr_r == `OFS_STAT);
  wire wr_hi_a  = ph_wr_r & (ph_addr_r == `OFS_CMPA_HI);

  // ----------------------------------------
  // Counter, comparators, output
  // ----------------------------------------
  wire run      = on & ~ctrl0_r[`C0_PAUSE];
  wire on_rise  = on & ~on_d_r;
  wire pwm_md   = (mode == `MODE_PWM);
  wire sp_md    = pwm_md & (io == `IO_11);
  wire trig     = (ctrl1_r[`C1_POL] ? eck_fall : eck_rise);
  wire cnt_en   = run & tick & (~sp_md | pulse_r);
  wire match_a  = cnt_en & (cnt_r == cmpa_r);
  wire match_p  = cnt_en & (cnt_r[15:8] == per_r);
  wire clr_a    = match_a & ctrl1_r[`C1_CCLR];
  wire clr_p    = match_p & ~ctrl1_r[`C1_CCLR];
  // Duty from A with period from P, or the reverse
  wire duty_m   = ctrl1_r[`C1_DPX] ? match_p : match_a;
  wire per_m    = ctrl1_r[`C1_DPX] ? match_a : match_p;
  reg  out_nxt;

  always @* begin
    out_nxt = out_r;
    if (on_rise)
      out_nxt = oc;
    else if (mode == `MODE_CMP && match_a) begin
      case (io)
        `IO_01:  out_nxt = 1'b0;
        `IO_10:  out_nxt = 1'b1;
        `IO_11:  out_nxt = ~out_r;
        default: out_nxt = out_r;
      endcase
    end else if (pwm_md) begin
      case (io)
        `IO_00:  out_nxt = ~oc;
        `IO_01:  out_nxt = oc;
        `IO_10:  out_nxt = per_m ? oc : (duty_m ? ~oc : out_r);
        default: out_nxt = (trig & ~pulse_r & run) ? oc :
                           (match_a ? ~oc : out_r);
      endcase
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r       <= `RST_WORD;
      out_r       <= 1'b0;
      on_d_r      <= 1'b0;
      pulse_r     <= 1'b0;
      stat_r      <= `RST_BYTE;
      match_a_evt <= 1'b0;
      match_p_evt <= 1'b0;
      capture_evt <= 1'b0;
      timer_output_pin          <= 1'b0;
      timer_output_inverted_pin <= 1'b1;
    end else begin
      on_d_r <= on;
      out_r  <= out_nxt;
      timer_output_pin          <= out_nxt;
      timer_output_inverted_pin <= ~out_nxt;
      match_a_evt <= match_a;
      match_p_evt <= match_p;
      capture_evt <= 1'b0;
      if (on_rise)
        cnt_r <= `RST_WORD;
      else if (clr_a || clr_p || (pwm_md && per_m))
        cnt_r <= `RST_WORD;
      else if (cnt_en)
        cnt_r <= cnt_r + 16'h0001;
      // Single pulse armed by trigger, ended by match A
      if (sp_md && run && trig)
        pulse_r <= 1'b1;
      else if (!sp_md || !run || match_a)
        pulse_r <= 1'b0;
      // Capture mode: latch counter into compare A
      if (on && mode == `MODE_CAP &&
          ((io == `IO_00 && cap_rise) || (io == `IO_01 && cap_fall) ||
           (io == `IO_10 && (cap_rise || cap_fall)))) begin
        capture_evt <= 1'b1;
      end
      // Sticky flags, set wins over write-one clear
      stat_r <= {5'h00,
        capture_evt | (stat_r[2] & ~(wr_stat & hwdata[2])),
        match_p     | (stat_r[1] & ~(wr_stat & hwdata[1])),
        match_a     | (stat_r[0] & ~(wr_stat & hwdata[0]))};
    end
  end

  // ----------------------------------------
  // AHB-Lite register access
  // ----------------------------------------
  wire ap_ok   = hsel & hready & (htrans == `HTRANS_NONSEQ);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      ph_addr_r <= `RST_BYTE;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr_r   <= ap_ok & hwrite;
      ph_rd_r   <= ap_ok & ~hwrite;
      ph_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl0_r <= `RST_BYTE;
      ctrl1_r <= `RST_BYTE;
      cmpa_r  <= `RST_WORD;
      per_r   <= `RST_BYTE;
      buf_r   <= `RST_BYTE;
      hrdata  <= 32'h0000_0000;
    end else begin
      hrdata <= 32'h0000_0000;
      if (ph_wr_r) begin
        case (ph_addr_r)
          `OFS_CTRL0:   ctrl0_r <= {hwdata[7:3], 3'h0};
          `OFS_CTRL1:   ctrl1_r <= hwdata[7:0];
          `OFS_CNT_LO,
          `OFS_CMPA_LO: buf_r   <= hwdata[7:0];
          `OFS_CMPA_HI: ;
          `OFS_PER:     per_r   <= hwdata[7:0];
          default:      ;
        endcase
      end
      if (wr_hi_a)
        cmpa_r <= {hwdata[7:0], buf_r};
      else if (capture_evt)
        cmpa_r <= cnt_r;
      // Read data launched at the address phase edge
      if (ap_ok && !hwrite) begin
        case (haddr[7:0])
          `OFS_CTRL0:   hrdata <= {24'h000000, ctrl0_r};
          `OFS_CTRL1:   hrdata <= {24'h000000, ctrl1_r};
          `OFS_CNT_LO,
          `OFS_CMPA_LO: hrdata <= {24'h000000, buf_r};
          `OFS_CNT_HI: begin
            hrdata <= {24'h000000, cnt_r[15:8]};
            buf_r  <= cnt_r[7:0];
          end
          `OFS_CMPA_HI: begin
            hrdata <= {24'h000000, cmpa_r[15:8]};
            buf_r  <= cmpa_r[7:0];
          end
          `OFS_PER:     hrdata <= {24'h000000, per_r};
          `OFS_STAT:    hrdata <= {24'h000000, stat_r};
          default:      hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// *** common/timer_core_map.vh ***
// Purpose: Register offsets, fields, codes of the timer core.
// Assumes: AHB-Lite, one 32-bit word per 8-bit register.
// Notes:   Data sits in bits 7:0, upper bits read zero.
`ifndef TIMER_CORE_MAP_VH
`define TIMER_CORE_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_CTRL0      8'h00
`define OFS_CTRL1      8'h04
`define OFS_CNT_LO     8'h08
`define OFS_CNT_HI     8'h0C
`define OFS_CMPA_LO    8'h10
`define OFS_CMPA_HI    8'h14
`define OFS_PER        8'h18
`define OFS_STAT       8'h1C

// ----------------------------------------
// Control 0 fields
// ----------------------------------------
`define C0_PAUSE       7
`define C0_CKS_HI      6
`define C0_CKS_LO      4
`define C0_ON          3
// ----------------------------------------
// Control 1 fields
// ----------------------------------------
`define C1_MODE_HI     7
`define C1_MODE_LO     6
`define C1_IO_HI       5
`define C1_IO_LO       4
`define C1_OC          3
`define C1_POL         2
`define C1_DPX         1
`define C1_CCLR        0

// ----------------------------------------
// Codes
// ----------------------------------------
`define CKS_SYS4       3'h0
`define CKS_SYS1       3'h1
`define CKS_H16        3'h2
`define CKS_H64        3'h3
`define CKS_EXT_RISE   3'h6
`define CKS_EXT_FALL   3'h7
`define MODE_CMP       2'h0
`define MODE_CAP       2'h1
`define MODE_PWM       2'h2
`define MODE_TMR       2'h3
`define IO_00          2'h0
`define IO_01          2'h1
`define IO_10          2'h2
`define IO_11          2'h3
`define DIV_SYS4       2'h3
`define DIV_H16        4'hF
`define DIV_H64        6'h3F
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define HTRANS_NONSEQ  2'h2
`define HSIZE_WORD     3'h2

`endif

// *** bench/timer_core_assertions.sv ***
// Purpose: Port checks for timer_core.
// Assumes: hready is fed from hreadyout.
// Notes:   Bound at the foot of this file.
`timescale 1ns/100ps
module timer_core_checker (
  // Bus
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Pins and events
  input wire        timer_output_pin,
  input wire        timer_output_inverted_pin,
  input wire        match_a_evt,
  input wire        match_p_evt,
  input wire        capture_evt
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pin_inverse: assert property (
    timer_output_inverted_pin != timer_output_pin)
    else $error("inverted pin not inverse");
  a_match_a_pulse: assert property (
    match_a_evt |=> !match_a_evt) else $error("match A too long");
  a_match_p_pulse: assert property (
    match_p_evt |=> !match_p_evt) else $error("match P too long");
  a_capture_pulse: assert property (
    capture_evt |=> !capture_evt) else $error("capture too long");
  a_rdata_idle: assert property (
    !(hsel && hready && htrans == 2'h2 && !hwrite) |=> hrdata == 32'h0)
    else $error("read data without read");
  a_rdata_byte: assert property (
    hrdata[31:8] == 24'h0) else $error("read data above byte");
  a_ready_high: assert property (
    hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (
    !hresp) else $error("error response seen");
endmodule

bind timer_core timer_core_checker u_chk (
  .clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .timer_output_pin(timer_output_pin),
  .timer_output_inverted_pin(timer_output_inverted_pin),
  .match_a_evt(match_a_evt), .match_p_evt(match_p_evt),
  .capture_evt(capture_evt));

// *** bench/pin_source.sv ***
// Purpose: Far side pins: external clock and capture input.
// Assumes: Edges several clk cycles apart.
// Notes:   Clock pin stands still while run is low.
`timescale 1ns/100ps
module pin_source (
  // Control
  input wire clk,
  input wire run,
  input wire cap_lvl,
  // Pins
  output reg ext_clock_pin,
  output reg capture_input_pin
);
  reg [1:0] div_r;
  initial begin
    div_r = 2'h0;
    ext_clock_pin = 1'h0;
    capture_input_pin = 1'h0;
  end
  // Slow edges so the synchroniser sees each one
  always @(posedge clk) begin
    div_r <= run ? div_r + 2'h1 : 2'h0;
    if (run && div_r == 2'h3)
      ext_clock_pin <= ~ext_clock_pin;
    capture_input_pin <= cap_lvl;
  end
endmodule

// *** bench/timer_core_test.sv ***
// Purpose: Self-checking bench for timer_core.
// Assumes: Zero wait state slave, pins from pin_source.
// Notes:   Periods measured between later matches.
`timescale 1ns/100ps
`include "timer_core_map.vh"
module timer_core_test;
  // Period is 4 shifted by this nibble, per clock code
  localparam [31:0] SH = 32'h33668602;
  localparam [7:0] CAPN = 8'h25;
  reg         clk = 1'h0;
  reg         rstn = 1'h0;
  reg         hsel = 1'h0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [6:0]  div = 7'h0;
  reg         run = 1'h0;
  reg         cap_lvl = 1'h0;
  wire [31:0] hrdata;
  wire        hready, hresp, ext, capin, pin, pin_n, ma, mp, ce;
  integer     n_fail = 0;
  integer     checks = 0;
  integer     ncap = 0;
  integer     c, i;

  timer_core i_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(`HSIZE_WORD),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .high_clock(div[1]),
    .sub_clock(div[5]), .ext_clock_pin(ext),
    .capture_input_pin(capin), .timer_output_pin(pin),
    .timer_output_inverted_pin(pin_n), .match_a_evt(ma),
    .match_p_evt(mp), .capture_evt(ce));
  pin_source u_pins (.clk(clk), .run(run), .cap_lvl(cap_lvl),
    .ext_clock_pin(ext), .capture_input_pin(capin));

  always #4 clk = ~clk;
  always @(posedge clk) div <= div + 7'h1;
  always @(posedge clk) if (ce) ncap <= ncap + 1;

  task chk(input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d, output [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    q = hrdata;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    reg [31:0] q;
    bus(1'h0, a, 8'h0, q);
    chk(q, {24'h0, e});
  endtask
  task start(input [7:0] c0, input [7:0] c1);
    wr(`OFS_CTRL0, 8'h00);
    wr(`OFS_CTRL1, c1);
    wr(`OFS_CTRL0, c0);
    @(posedge clk);
  endtask
  task tick(input p, output integer n);
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while ((p ? mp : ma) !== 1'h1 && n < 4000);
    if (n >= 4000) chk(32'h0, 32'h1);
  endtask
  task complete_run;
    if (n_fail == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #400000;
    chk(32'h0, 32'h1);
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd(`OFS_CTRL0, `RST_BYTE);
    rd(`OFS_CTRL1, `RST_BYTE);
    rd(8'h20, 8'h00);
    wr(`OFS_CMPA_LO, 8'h34);
    rd(`OFS_CMPA_LO, 8'h34);
    rd(`OFS_CMPA_HI, 8'h00);
    rd(`OFS_CMPA_LO, 8'h00);
    wr(`OFS_CMPA_LO, 8'h34);
    wr(`OFS_CMPA_HI, 8'h12);
    rd(`OFS_CMPA_HI, 8'h12);
    rd(`OFS_CMPA_LO, 8'h34);
    wr(`OFS_PER, 8'h01);
    rd(`OFS_PER, 8'h01);
    wr(`OFS_CMPA_LO, 8'h03);
    wr(`OFS_CMPA_HI, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      run <= (i > 5);
      start({1'h0, i[2:0], 4'h8}, 8'h31);
      tick(1'h0, c);
      tick(1'h0, c);
      tick(1'h0, c);
      chk(c, 4 << SH[4*i +: 4]);
    end
    run <= 1'h0;
    for (i = 1; i < 4; i = i + 1) begin
      start(8'h08, {2'h0, i[1:0], i == 1, 3'h1});
      @(posedge clk);
      chk(pin, i == 1);
      tick(1'h0, c);
      repeat (2) @(posedge clk);
      chk(pin, i != 1);
      chk(pin_n, i == 1);
    end
    start(8'h18, 8'hC0);
    tick(1'h1, c);
    tick(1'h1, c);
    chk(c, 32'h101);
    wr(`OFS_CTRL0, 8'h00);
    rd(`OFS_STAT, 8'h03);
    wr(`OFS_STAT, 8'h03);
    rd(`OFS_STAT, 8'h00);
    start(8'h18, 8'hA8);
    tick(1'h1, c);
    for (c = 0; pin === 1'h1 && c < 300; c = c + 1)
      @(posedge clk);
    chk(c, 32'h4);
    chk(pin_n, 32'h1);
    run <= 1'h1;
    start(8'h18, 8'hB8);
    tick(1'h0, c);
    chk(pin, 32'h0);
    run <= 1'h0;
    for (i = 0; i < 4; i = i + 1) begin
      start(8'h18, {2'h1, i[1:0], 4'h0});
      c = ncap;
      cap_lvl <= 1'h1;
      repeat (8) @(posedge clk);
      cap_lvl <= 1'h0;
      repeat (8) @(posedge clk);
      chk(ncap - c, CAPN[2*i +: 2]);
    end
    complete_run;
  end
endmodule
